/* File: logic/usba_pkg.sv */
// constants and carrier types for the serial port shadow buffer access block
package usba_pkg;
  // register byte addresses
  localparam logic [31:0] USBA_SHADOW_BASE = 32'h5000_1130; // alias 0 of sixteen
  localparam logic [31:0] USBA_SHADOW_LAST = 32'h5000_116C; // alias 15
  localparam logic [31:0] USBA_SHADOW_12 = 32'h5000_1160; // second_uart_shadow_buffer_12
  localparam logic [31:0] USBA_SHADOW_13 = 32'h5000_1164; // second_uart_shadow_buffer_13
  localparam logic [31:0] USBA_MAIN_BUF = 32'h5000_1100; // receive_buffer / transmit_holding
  localparam logic [31:0] USBA_FIFO_CTRL = 32'h5000_1108; // fifo_control_reg
  localparam logic [31:0] USBA_LINE_STAT = 32'h5000_1114; // line_status_reg
  localparam logic [31:0] USBA_IRQ_STAT = 32'h5000_1180; // sticky events, cleared by read
  localparam logic [31:0] USBA_IRQ_MASK = 32'h5000_1184; // event enables
  localparam logic [31:0] USBA_MODE = 32'h5000_1188; // line mode select
  // field positions
  localparam int USBA_FC_ENABLE = 0; // fifo enable
  localparam int USBA_FC_RX_FLUSH = 1; // self-clearing receive flush
  localparam int USBA_FC_TX_FLUSH = 2; // self-clearing transmit flush
  localparam int USBA_LS_DR = 0; // data_ready_flag
  localparam int USBA_LS_OE = 1; // overrun error
  localparam int USBA_LS_TX_HOLDING_EMPTY_FLAG = 5; // tx_holding_empty_flag
  localparam int USBA_LS_TEMT = 6; // holding and output stage both empty
  localparam int USBA_MODE_IR = 0; // infrared line when set
  localparam int USBA_EV_RX = 0; // character stored
  localparam int USBA_EV_OVR = 1; // overrun
  localparam int USBA_EV_TX_HOLDING_EMPTY_FLAG = 2; // holding became empty
  localparam int USBA_EV_TXDROP = 3; // write lost to a full holding fifo
  localparam int USBA_EV_W = 4;
  // widths and reset values
  localparam int USBA_CHAR_W = 8;
  localparam int USBA_DEF_DEPTH = 16;
  localparam logic [31:0] USBA_ZERO_WORD = 32'h0000_0000;
  localparam logic [USBA_EV_W-1:0] USBA_EV_RST = 4'h0;
  localparam logic [1:0] USBA_RESP_OKAY = 2'h0;
  localparam logic [1:0] USBA_RESP_DECERR = 2'h3;

  // one character on a line stream
  typedef struct packed {
    logic valid;
    logic [USBA_CHAR_W-1:0] data;
  } usba_char_t;

  // line selected for the output stage
  typedef enum logic [0:0] {
    USBA_LINE_SERIAL = 1'b0,
    USBA_LINE_IR = 1'b1
  } usba_line_t;
endpackage

/* File: logic/usba_shadow_buffer.sv */
// shadow receive/transmit buffer access over AXI4-Lite with fifos and interrupt
`timescale 1ns/10ps
// Functional notes
// R1: sixteen word-spaced shadow addresses all alias the receive/transmit buffer.
// R2: shadow read low byte returns character from serial or infrared input per mode.
// R3: software trusts read byte only while data ready flag is set.
// R4: fifos off, new character overwrites unread byte and flags overrun.
// R5: fifos on, shadow read returns receive fifo head.
// R6: receive fifo full, incoming character dropped, stored kept, overrun flagged.
// R7: shadow write low byte sends character to serial or infrared output.
// R8: software writes transmit data only while holding-empty flag is set.
// R9: fifos off, a character write clears the holding-empty flag.
// R10: fifos off, further writes before empty replace pending character.
// R11: fifos on, depth writes accepted (default sixteen) before full.
// R12: writes into a full transmit fifo are dropped unchanged.
// R13: shadow read pops receive fifo and updates data ready like main read.
module usba_shadow_buffer import usba_pkg::*; #(
  parameter int DEPTH = USBA_DEF_DEPTH
) (
  input wire logic mclk, // 125 MHz clock
  input wire logic srst, // synchronous reset, active high
  input wire logic [31:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address taken
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte lanes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data taken
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response accepted
  input wire logic [31:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address taken
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data accepted
  input wire usba_char_t rx_serial_char, // character from serial deserializer
  input wire usba_char_t rx_ir_char, // character from infrared decoder
  output usba_char_t tx_serial_char, // character to serial serializer
  input wire logic tx_serial_ready, // serial serializer takes character
  output usba_char_t tx_ir_char, // character to infrared encoder
  input wire logic tx_ir_ready, // infrared encoder takes character
  output logic irq // level interrupt
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
  localparam logic [PTR_W:0] CNT_FULL = (PTR_W + 1)'(DEPTH);
  localparam logic [PTR_W-1:0] PTR_ZERO = '0;
  localparam logic [PTR_W:0] CNT_ZERO = '0;
  localparam logic [PTR_W:0] CNT_ONE = (PTR_W + 1)'(1);

  // bus side state
  logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;
  // control and status state
  logic fifo_en_reg, ir_mode_reg, overrun_reg, irq_reg;
  logic [USBA_EV_W-1:0] ev_stat_reg, ev_mask_reg;
  // receive fifo
  logic [USBA_CHAR_W-1:0] rx_mem [DEPTH];
  logic [PTR_W-1:0] rx_wr_ptr_reg, rx_rd_ptr_reg;
  logic [PTR_W:0] rx_count_reg;
  // transmit fifo and output stage
  logic [USBA_CHAR_W-1:0] tx_mem [DEPTH];
  logic [PTR_W-1:0] tx_wr_ptr_reg, tx_rd_ptr_reg;
  logic [PTR_W:0] tx_count_reg;
  usba_char_t tx_serial_reg, tx_ir_reg;

  // handshakes and decode
  logic wr_hs, rd_hs, wr_buf, rd_buf, wr_map, rd_map, wr_low;
  logic fc_write, rx_flush, tx_flush;
  usba_char_t rx_in;
  logic rx_full, rx_pop, rx_push, rx_over, rx_drop;
  logic tx_full, tx_push, tx_over, tx_drop, tx_take, tx_load, tx_stage_busy;
  logic tx_holding_empty_flag_now, tx_holding_empty_flag_rise_q;
  logic [31:0] rd_word;

  assign wr_hs = awready_reg;
  assign rd_hs = arready_reg;

  // alias decode: any aligned word in the shadow window or the main buffer address
  function automatic logic usba_is_buf(input logic [31:0] a);
    usba_is_buf = (a == USBA_MAIN_BUF) ||
                  (a >= USBA_SHADOW_BASE && a <= USBA_SHADOW_LAST && a[1:0] == 2'h0); // R1
  endfunction

  function automatic logic usba_is_map(input logic [31:0] a);
    usba_is_map = usba_is_buf(a) || a == USBA_FIFO_CTRL || a == USBA_LINE_STAT ||
                  a == USBA_IRQ_STAT || a == USBA_IRQ_MASK || a == USBA_MODE;
  endfunction

  assign wr_buf = wr_hs && usba_is_buf(s_axi_awaddr);
  assign rd_buf = rd_hs && usba_is_buf(s_axi_araddr);
  assign wr_map = usba_is_map(s_axi_awaddr);
  assign rd_map = usba_is_map(s_axi_araddr);
  // lane 0 alone qualifies byte writes; the upper lanes carry nothing in this map
  assign wr_low = s_axi_wstrb[0];
  assign fc_write = wr_hs && s_axi_awaddr == USBA_FIFO_CTRL && wr_low;
  // changing the fifo mode empties both queues so stale depth never leaks across
  assign rx_flush = fc_write && (s_axi_wdata[USBA_FC_RX_FLUSH] ||
                                 s_axi_wdata[USBA_FC_ENABLE] != fifo_en_reg);
  assign tx_flush = fc_write && (s_axi_wdata[USBA_FC_TX_FLUSH] ||
                                 s_axi_wdata[USBA_FC_ENABLE] != fifo_en_reg);

  // write channel: address and data taken together, one write at a time
  always_ff @(posedge mclk) begin
    if (srst) begin
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= USBA_RESP_OKAY;
    end else begin
      // both readies rise together and only while both valids stand, so a write is never half taken
      awready_reg <= !awready_reg && !bvalid_reg && s_axi_awvalid && s_axi_wvalid;
      wready_reg <= !awready_reg && !bvalid_reg && s_axi_awvalid && s_axi_wvalid;
      if (wr_hs) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_map ? USBA_RESP_OKAY : USBA_RESP_DECERR;
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // read word mux; unmapped addresses read zero
  always_comb begin
    rd_word = USBA_ZERO_WORD;
    if (usba_is_buf(s_axi_araddr)) begin
      rd_word[USBA_CHAR_W-1:0] = rx_mem[rx_rd_ptr_reg]; // R2 R5
    end else if (s_axi_araddr == USBA_FIFO_CTRL) begin
      rd_word[USBA_FC_ENABLE] = fifo_en_reg;
    end else if (s_axi_araddr == USBA_LINE_STAT) begin
      rd_word[USBA_LS_DR] = rx_count_reg != CNT_ZERO; // R3
      rd_word[USBA_LS_OE] = overrun_reg;
      rd_word[USBA_LS_TX_HOLDING_EMPTY_FLAG] = tx_holding_empty_flag_now; // R8
      rd_word[USBA_LS_TEMT] = tx_holding_empty_flag_now && !tx_stage_busy;
    end else if (s_axi_araddr == USBA_IRQ_STAT) begin
      rd_word[USBA_EV_W-1:0] = ev_stat_reg;
    end else if (s_axi_araddr == USBA_IRQ_MASK) begin
      rd_word[USBA_EV_W-1:0] = ev_mask_reg;
    end else if (s_axi_araddr == USBA_MODE) begin
      rd_word[USBA_MODE_IR] = ir_mode_reg;
    end
  end

  // read channel: data captured at the address handshake, answer one cycle later
  always_ff @(posedge mclk) begin
    if (srst) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= USBA_ZERO_WORD;
      rresp_reg <= USBA_RESP_OKAY;
    end else begin
      // the answer holds until rready; no second read is taken meanwhile
      arready_reg <= !arready_reg && !rvalid_reg && s_axi_arvalid;
      if (rd_hs) begin
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_word;
        rresp_reg <= rd_map ? USBA_RESP_OKAY : USBA_RESP_DECERR;
      end else if (s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // control registers written by software
  always_ff @(posedge mclk) begin
    if (srst) begin
      fifo_en_reg <= 1'b0;
      ir_mode_reg <= 1'b0;
      ev_mask_reg <= USBA_EV_RST;
    end else if (wr_hs && wr_low) begin
      if (s_axi_awaddr == USBA_FIFO_CTRL) begin
        fifo_en_reg <= s_axi_wdata[USBA_FC_ENABLE];
      end
      if (s_axi_awaddr == USBA_MODE) begin
        ir_mode_reg <= s_axi_wdata[USBA_MODE_IR];
      end
      if (s_axi_awaddr == USBA_IRQ_MASK) begin
        ev_mask_reg <= s_axi_wdata[USBA_EV_W-1:0];
      end
    end
  end

  // receive side: line selected by mode, capacity one when fifos are off
  // trade-off: fifos off reuses the same memory at depth one instead of a separate register
  assign rx_in = ir_mode_reg ? rx_ir_char : rx_serial_char; // R2
  assign rx_full = fifo_en_reg ? (rx_count_reg == CNT_FULL) : (rx_count_reg != CNT_ZERO);
  assign rx_pop = rd_buf && rx_count_reg != CNT_ZERO; // R13
  assign rx_push = rx_in.valid && (!rx_full || rx_pop);
  assign rx_over = rx_in.valid && !rx_push && !fifo_en_reg; // R4
  assign rx_drop = rx_in.valid && !rx_push && fifo_en_reg; // R6

  // receive storage; an overwrite replaces the single unread byte in place.
  // reset clears every entry, so a read of the empty buffer after reset shows
  // the register's reset value of zero rather than an unknown byte
  always_ff @(posedge mclk) begin
    if (srst) begin
      for (int i = 0; i < DEPTH; i++) begin
        rx_mem[i] <= '0;
      end
    end else if (rx_push) begin
      rx_mem[rx_wr_ptr_reg] <= rx_in.data;
    end else if (rx_over) begin
      rx_mem[rx_rd_ptr_reg] <= rx_in.data; // R4
    end
  end

  // receive pointers and count; a full fifo leaves the stored entries alone
  always_ff @(posedge mclk) begin
    if (srst || rx_flush) begin
      rx_wr_ptr_reg <= PTR_ZERO;
      rx_rd_ptr_reg <= PTR_ZERO;
      rx_count_reg <= CNT_ZERO;
    end else begin
      if (rx_push) begin
        rx_wr_ptr_reg <= (rx_wr_ptr_reg == PTR_LAST) ? PTR_ZERO : rx_wr_ptr_reg + 1'b1;
      end
      if (rx_pop) begin
        rx_rd_ptr_reg <= (rx_rd_ptr_reg == PTR_LAST) ? PTR_ZERO : rx_rd_ptr_reg + 1'b1; // R5 R13
      end
      case ({rx_push, rx_pop})
        2'b10: rx_count_reg <= rx_count_reg + CNT_ONE;
        2'b01: rx_count_reg <= rx_count_reg - CNT_ONE;
        default: rx_count_reg <= rx_count_reg; // R6
      endcase
    end
  end

  // overrun flag: cleared by a line status read, a new overrun in that cycle wins
  always_ff @(posedge mclk) begin
    if (srst) begin
      overrun_reg <= 1'b0;
    end else if (rx_over || rx_drop) begin
      overrun_reg <= 1'b1; // R4 R6
    end else if (rd_hs && s_axi_araddr == USBA_LINE_STAT) begin
      overrun_reg <= 1'b0;
    end
  end

  // transmit side: the holding queue feeds a one-entry output stage
  // limitation: with fifos off the queue is one entry deep, so on a slow line later
  // writes replace the pending character rather than wait behind it
  assign tx_stage_busy = tx_serial_reg.valid || tx_ir_reg.valid;
  assign tx_take = (tx_serial_reg.valid && tx_serial_ready) || (tx_ir_reg.valid && tx_ir_ready);
  assign tx_load = (!tx_stage_busy || tx_take) && tx_count_reg != CNT_ZERO;
  assign tx_full = fifo_en_reg ? (tx_count_reg == CNT_FULL) : (tx_count_reg != CNT_ZERO); // R11
  assign tx_push = wr_buf && wr_low && (!tx_full || tx_load); // R7
  assign tx_over = wr_buf && wr_low && !tx_push && !fifo_en_reg; // R10
  assign tx_drop = wr_buf && wr_low && !tx_push && fifo_en_reg; // R12
  assign tx_holding_empty_flag_now = tx_count_reg == CNT_ZERO; // R9

  // transmit storage; fifos off, a pending character is simply replaced
  always_ff @(posedge mclk) begin
    if (tx_push) begin
      tx_mem[tx_wr_ptr_reg] <= s_axi_wdata[USBA_CHAR_W-1:0];
    end else if (tx_over) begin
      tx_mem[tx_rd_ptr_reg] <= s_axi_wdata[USBA_CHAR_W-1:0]; // R10
    end
  end

  // transmit pointers and count; a dropped write touches nothing
  always_ff @(posedge mclk) begin
    if (srst || tx_flush) begin
      tx_wr_ptr_reg <= PTR_ZERO;
      tx_rd_ptr_reg <= PTR_ZERO;
      tx_count_reg <= CNT_ZERO;
    end else begin
      if (tx_push) begin
        tx_wr_ptr_reg <= (tx_wr_ptr_reg == PTR_LAST) ? PTR_ZERO : tx_wr_ptr_reg + 1'b1; // R11
      end
      if (tx_load) begin
        tx_rd_ptr_reg <= (tx_rd_ptr_reg == PTR_LAST) ? PTR_ZERO : tx_rd_ptr_reg + 1'b1;
      end
      case ({tx_push, tx_load})
        2'b10: tx_count_reg <= tx_count_reg + CNT_ONE; // R9
        2'b01: tx_count_reg <= tx_count_reg - CNT_ONE;
        default: tx_count_reg <= tx_count_reg; // R12
      endcase
    end
  end

  // output stage: the line is chosen when the character leaves the queue
  always_ff @(posedge mclk) begin
    if (srst) begin
      tx_serial_reg <= '0;
      tx_ir_reg <= '0;
    end else if (tx_load) begin
      tx_serial_reg.valid <= usba_line_t'(ir_mode_reg) == USBA_LINE_SERIAL; // R7
      tx_ir_reg.valid <= usba_line_t'(ir_mode_reg) == USBA_LINE_IR; // R7
      tx_serial_reg.data <= tx_mem[tx_rd_ptr_reg];
      tx_ir_reg.data <= tx_mem[tx_rd_ptr_reg];
    end else if (tx_take) begin
      tx_serial_reg.valid <= 1'b0;
      tx_ir_reg.valid <= 1'b0;
    end
  end

  // holding-empty edge, so the event fires once per emptying
  // reset value matches the empty queue so no false event follows reset
  always_ff @(posedge mclk) begin
    if (srst) begin
      tx_holding_empty_flag_rise_q <= 1'b1;
    end else begin
      tx_holding_empty_flag_rise_q <= tx_holding_empty_flag_now;
    end
  end

  // sticky events: read of the status word clears, an event in the same cycle survives
  always_ff @(posedge mclk) begin
    if (srst) begin
      ev_stat_reg <= USBA_EV_RST;
    end else begin
      ev_stat_reg <= ((rd_hs && s_axi_araddr == USBA_IRQ_STAT) ? USBA_EV_RST : ev_stat_reg) |
                     {tx_drop, tx_holding_empty_flag_now && !tx_holding_empty_flag_rise_q, rx_over || rx_drop, rx_push};
    end
  end

  // interrupt level follows the masked status one cycle later
  // the extra cycle of lag keeps irq straight from a flip-flop
  always_ff @(posedge mclk) begin
    if (srst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(ev_stat_reg & ev_mask_reg);
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign tx_serial_char = tx_serial_reg;
  assign tx_ir_char = tx_ir_reg;
  assign irq = irq_reg;
endmodule

/* File: testbench/tb_top.sv */
// self-checking bench for the shadow buffer access block
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR %0t: got %0h want %0h", $time, g, e); end end
module tb_top import usba_pkg::*; ;
  localparam int DEP = 4; // short fifo keeps full cases quick
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, rd;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, stall = 1'b0;
  logic bready = 1'b1, rready = 1'b1; // always ready for answers
  logic awready, wready, bvalid, arready, rvalid, irq, txs_rdy, txi_rdy;
  logic [1:0] bresp, rresp, rs;
  usba_char_t rxs, rxi, txs, txi;
  int mismatches = 0;
  int checks_done = 0;
  usba_shadow_buffer #(.DEPTH(DEP)) dut_u (.mclk(mclk), .srst(srst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .rx_serial_char(rxs), .rx_ir_char(rxi), .tx_serial_char(txs), .tx_serial_ready(txs_rdy),
    .tx_ir_char(txi), .tx_ir_ready(txi_rdy), .irq(irq));
  usba_line_peer peer_u (.mclk(mclk), .stall(stall), .tx_serial_char(txs), .tx_ir_char(txi),
    .rx_serial_char(rxs), .rx_ir_char(rxi), .tx_serial_ready(txs_rdy), .tx_ir_ready(txi_rdy));
  // 125 MHz clock
  initial forever #4 mclk = ~mclk;
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic hang();
    mismatches++;
    $display("ERROR %0t: bus timeout", $time);
    results();
  endtask
  // one write; address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        rs = bresp;
        return;
      end
    end
    hang();
  endtask
  task automatic axi_rd(input logic [31:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        rd = rdata;
        rs = rresp;
        return;
      end
    end
    hang();
  endtask
  // waits a bounded time for the peer to collect n chars
  task automatic drain(input int n);
    for (int k = 0; k < 100 && peer_u.got_q.size() < n; k++) @(posedge mclk);
    `CHK(peer_u.got_q.size(), n)
  endtask
  task automatic t_regs();
    axi_rd(USBA_SHADOW_12);
    `CHK({rs, rd}, {USBA_RESP_OKAY, USBA_ZERO_WORD})
    axi_rd(USBA_SHADOW_13);
    `CHK({rs, rd}, {USBA_RESP_OKAY, USBA_ZERO_WORD})
    axi_rd(USBA_LINE_STAT);
    `CHK(rd[USBA_LS_TX_HOLDING_EMPTY_FLAG], 1'b1)
    axi_rd(32'h5000_11FC);
    `CHK(rs, USBA_RESP_DECERR)
    axi_wr(32'h5000_11FC, 32'h0000_00A5);
    `CHK(rs, USBA_RESP_DECERR)
    $display("test regs done");
  endtask
  // every alias reaches the receive buffer and pops it
  task automatic t_alias();
    for (int a = 0; a < 16; a++) begin
      peer_u.send(1'b0, 8'h30 + 8'(a));
      axi_rd(USBA_SHADOW_BASE + 32'(4 * a));
      `CHK(rd, 32'h30 + 32'(a))
    end
    peer_u.send(1'b0, 8'h11);
    peer_u.send(1'b0, 8'h22);
    axi_rd(USBA_LINE_STAT);
    `CHK(rd[1:0], 2'h3)
    axi_rd(USBA_SHADOW_13);
    `CHK(rd, 32'h0000_0022)
    axi_rd(USBA_LINE_STAT);
    `CHK(rd[1:0], 2'h0)
    $display("test alias done");
  endtask
  task automatic t_tx_off();
    stall <= 1'b1;
    axi_wr(USBA_SHADOW_12, 32'h0000_0041);
    repeat (3) @(posedge mclk);
    axi_wr(USBA_SHADOW_13, 32'h0000_0042);
    axi_rd(USBA_LINE_STAT);
    `CHK(rd[USBA_LS_TX_HOLDING_EMPTY_FLAG], 1'b0)
    axi_wr(USBA_SHADOW_12, 32'h0000_0043);
    stall <= 1'b0;
    drain(2);
    `CHK(peer_u.got_q[0], 9'h041)
    `CHK(peer_u.got_q[1], 9'h043)
    peer_u.got_q.delete();
    $display("test tx off done");
  endtask
  task automatic t_rx_fifo();
    axi_wr(USBA_FIFO_CTRL, 32'h0000_0001);
    for (int i = 0; i <= DEP; i++) peer_u.send(1'b0, 8'hA0 + 8'(i));
    axi_rd(USBA_LINE_STAT);
    `CHK(rd[1:0], 2'h3)
    for (int i = 0; i < DEP; i++) begin
      axi_rd(USBA_SHADOW_BASE + 32'(4 * i));
      `CHK(rd, 32'hA0 + 32'(i))
    end
    axi_rd(USBA_LINE_STAT);
    `CHK(rd[USBA_LS_DR], 1'b0)
    $display("test rx fifo done");
  endtask
  // output stage plus DEP queued are kept, the next write is lost
  task automatic t_tx_fifo();
    stall <= 1'b1;
    for (int i = 0; i < DEP + 2; i++) axi_wr(USBA_SHADOW_BASE + 32'(4 * i), 32'h60 + 32'(i));
    axi_rd(USBA_IRQ_STAT);
    `CHK(rd[USBA_EV_TXDROP], 1'b1)
    stall <= 1'b0;
    drain(DEP + 1);
    for (int i = 0; i <= DEP; i++) `CHK(peer_u.got_q[i], 9'h060 + 9'(i))
    peer_u.got_q.delete();
    $display("test tx fifo done");
  endtask
  task automatic t_ir();
    axi_wr(USBA_MODE, 32'h0000_0001);
    peer_u.send(1'b1, 8'h5A);
    axi_rd(USBA_LINE_STAT);
    `CHK(rd[USBA_LS_DR], 1'b1)
    `CHK(rd[USBA_LS_TX_HOLDING_EMPTY_FLAG], 1'b1)
    axi_rd(USBA_SHADOW_12);
    `CHK(rd, 32'h0000_005A)
    axi_wr(USBA_SHADOW_13, 32'h0000_003C);
    drain(1);
    `CHK(peer_u.got_q[0], 9'h13C)
    peer_u.got_q.delete();
    axi_wr(USBA_MODE, 32'h0000_0000);
    $display("test infrared done");
  endtask
  task automatic t_irq();
    axi_rd(USBA_IRQ_STAT);
    axi_wr(USBA_IRQ_MASK, 32'h0000_0001);
    peer_u.send(1'b0, 8'h77);
    repeat (2) @(posedge mclk);
    `CHK(irq, 1'b1)
    axi_rd(USBA_IRQ_STAT);
    `CHK(rd[USBA_EV_RX], 1'b1)
    repeat (2) @(posedge mclk);
    `CHK(irq, 1'b0)
    axi_wr(USBA_IRQ_MASK, 32'h0000_0000);
    peer_u.send(1'b0, 8'h78);
    repeat (2) @(posedge mclk);
    `CHK(irq, 1'b0)
    $display("test irq done");
  endtask
  // main sequence
  initial begin
    repeat (8) @(posedge mclk);
    srst <= 1'b0;
    t_regs();
    t_alias();
    t_tx_off();
    t_rx_fifo();
    t_tx_fifo();
    t_ir();
    t_irq();
    results();
  end
endmodule

/* File: testbench/usba_line_peer.sv */
// line-side peer: sends characters into the block and takes its output
`timescale 1ns/10ps
module usba_line_peer import usba_pkg::*; (
  input wire logic mclk, // clock
  input wire logic stall, // holds off taking output
  input wire usba_char_t tx_serial_char, // block serial output
  input wire usba_char_t tx_ir_char, // block infrared output
  output usba_char_t rx_serial_char, // block serial input
  output usba_char_t rx_ir_char, // block infrared input
  output logic tx_serial_ready, // serial char taken
  output logic tx_ir_ready // infrared char taken
);
  logic [8:0] got_q[$]; // taken chars, line flag on top
  initial begin
    rx_serial_char = 9'h0AA;
    rx_ir_char = 9'h055;
  end
  // a stalled peer is how a slow line looks to the block
  assign tx_serial_ready = !stall;
  assign tx_ir_ready = !stall;
  // one-cycle pulse; then inverse data so a stale byte never matches
  task automatic send(input logic ir, input logic [7:0] d);
    @(posedge mclk);
    if (ir) rx_ir_char <= {1'b1, d};
    else rx_serial_char <= {1'b1, d};
    @(posedge mclk);
    if (ir) rx_ir_char <= {1'b0, ~d};
    else rx_serial_char <= {1'b0, ~d};
  endtask
  // record each char handed over
  always @(posedge mclk) begin
    if (tx_serial_char.valid && tx_serial_ready) got_q.push_back({1'b0, tx_serial_char.data});
    if (tx_ir_char.valid && tx_ir_ready) got_q.push_back({1'b1, tx_ir_char.data});
  end
endmodule

/* File: testbench/usba_shadow_buffer_assertions.sv */
// concurrent checks on the ports of the shadow buffer access block
`timescale 1ns/10ps
module usba_shadow_chk import usba_pkg::*; #(
  parameter int DEPTH = USBA_DEF_DEPTH
) (
  input wire logic mclk, // clock
  input wire logic srst, // sync reset
  input wire logic s_axi_awready, // write address taken
  input wire logic s_axi_wready, // write data taken
  input wire logic [1:0] s_axi_bresp, // write response
  input wire logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response accepted
  input wire logic s_axi_arready, // read address taken
  input wire logic [31:0] s_axi_rdata, // read data
  input wire logic [1:0] s_axi_rresp, // read response
  input wire logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data accepted
  input wire usba_char_t tx_serial_char, // serial output
  input wire logic tx_serial_ready, // serial take
  input wire usba_char_t tx_ir_char, // infrared output
  input wire logic tx_ir_ready // infrared take
);
  default clocking dck @(posedge mclk); endclocking
  default disable iff (srst);
  // bus channel timing and holding
  property p_pair; s_axi_awready |-> s_axi_wready; endproperty
  a_pair: assert property (p_pair) else $error("write address and data taken apart");
  property p_bresp; s_axi_awready |=> s_axi_bvalid && !s_axi_awready; endproperty
  a_bresp: assert property (p_bresp) else $error("write response late");
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  property p_busy; s_axi_bvalid |-> !s_axi_awready; endproperty
  a_busy: assert property (p_busy) else $error("write taken while answering");
  property p_rresp; s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
  a_rresp: assert property (p_rresp) else $error("read data late");
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped");
  property p_rbyte; s_axi_rvalid && s_axi_rresp == USBA_RESP_OKAY |-> s_axi_rdata[31:8] == 24'h0; endproperty
  a_rbyte: assert property (p_rbyte) else $error("upper read bits set");
  // output characters hold until taken; one output stage feeds one line
  property p_shold; tx_serial_char.valid && !tx_serial_ready |=> $stable(tx_serial_char); endproperty
  a_shold: assert property (p_shold) else $error("serial char changed");
  property p_ihold; tx_ir_char.valid && !tx_ir_ready |=> $stable(tx_ir_char); endproperty
  a_ihold: assert property (p_ihold) else $error("infrared char changed");
  property p_oneline; !(tx_serial_char.valid && tx_ir_char.valid); endproperty
  a_oneline: assert property (p_oneline) else $error("both lines driven");
endmodule
bind usba_shadow_buffer usba_shadow_chk #(.DEPTH(DEPTH)) chk_u (.mclk, .srst, .s_axi_awready, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .tx_serial_char, .tx_serial_ready, .tx_ir_char, .tx_ir_ready);
